// ---- design/cirbd_defines.svh ----
// Constants for the infrared baud divisor, demodulation window and
// transmit level block. Assumes a classic Wishbone slave, 8-bit data.
`ifndef CIRBD_DEFINES_SVH
`define CIRBD_DEFINES_SVH
`define CIRBD_OFF_CTRL      3'h4
`define CIRBD_OFF_LOW       3'h5
`define CIRBD_OFF_HIGH      3'h6
`define CIRBD_OFF_BANK      3'h7
`define CIRBD_CFQ_MSB       7
`define CIRBD_CFQ_LSB       3
`define CIRBD_CFQ_RESET     5'h0b
`define CIRBD_CTRL_LOW_RST  3'h4
`define CIRBD_DIV_RESET     8'h00
`define CIRBD_BANK_RESET    8'h04
`define CIRBD_BANK_BIT      0
`define CIRBD_HIGH_CARRIER_SELECT_BIT      1
`define CIRBD_RANGE_LSB     2
`define CIRBD_RANGE_MSB     4
`define CIRBD_COUNT_W       6
`endif

// ---- design/cirbd_pkg.sv ----
// Types for the infrared baud and demodulation block.
// Assumes cirbd_defines.svh is included by the design file.
package cirbd_pkg;
   typedef logic [4:0] cirbd_code_type;
   typedef logic [2:0] cirbd_range_type;
   // Window bounds in units of 1/16 kHz for fixed-point compare
   typedef logic [15:0] cirbd_khz_type;
endpackage

// ---- design/cirbd_top.sv ----
// Baud divisor, demodulation acceptance window and transmit level status.
// Assumes a classic Wishbone slave, byte data on the low lane.
//
// Design decision made here: the Wishbone interface to the registers.
`include "cirbd_defines.svh"
module cirbd_top (
   // Clock and control
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   // Wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [2:0]  adr_i,
   input  wire logic [0:0]  sel_i,
   input  wire logic [7:0]  dat_i,
   output logic      [7:0]  dat_o,
   output logic             ack_o,
   // Transmit FIFO level from the data path
   input  wire logic [5:0]  tx_fifo_byte_count_i,
   // Measured carrier frequency, 1/16 kHz units, with strobe
   input  wire logic [15:0] carrier_khz16_i,
   input  wire logic        carrier_valid_i,
   // Results
   output logic             carrier_accept_o,
   output logic             baud_tick_o
);
   logic [7:0]  ctrl, next_ctrl;
   logic [7:0]  div_low, next_div_low;
   logic [7:0]  div_high, next_div_high;
   logic [7:0]  bank, next_bank;
   logic [7:0]  next_dat;
   logic        next_ack;
   logic [15:0] baud_cnt, next_baud_cnt;
   logic        next_tick;
   logic        next_accept;
   logic        bank_select_bit;
   logic        high_carrier_select;
   cirbd_pkg::cirbd_code_type  carrier_freq_code;
   cirbd_pkg::cirbd_range_type demod_range_code;
   cirbd_pkg::cirbd_khz_type   win_min, win_max, nominal;
   logic        wr;

   assign bank_select_bit     = bank[`CIRBD_BANK_BIT];
   assign high_carrier_select = bank[`CIRBD_HIGH_CARRIER_SELECT_BIT];
   assign demod_range_code    = bank[`CIRBD_RANGE_MSB:`CIRBD_RANGE_LSB];
   assign carrier_freq_code   = ctrl[`CIRBD_CFQ_MSB:`CIRBD_CFQ_LSB];
   assign wr = cyc_i & stb_i & we_i & sel_i[0] & ~ack_o;

   // Nominal carrier, 1/16 kHz units
   function automatic cirbd_pkg::cirbd_khz_type nom_f(
      input cirbd_pkg::cirbd_code_type c, input logic hi);
      if (hi) begin
         case (c)
            5'h03:   nom_f = 16'(400 * 16);
            5'h08:   nom_f = 16'(450 * 16);
            5'h0d:   nom_f = 16'(500 * 16);
            default: nom_f = 16'(480 * 16);
         endcase
      end else begin
         nom_f = 16'((27 + 32'(c)) * 16);
      end
   endfunction

   // Half-width is nominal times range/16 (range 1 gives 30..34 at 32k)
   function automatic cirbd_pkg::cirbd_khz_type half_f(
      input cirbd_pkg::cirbd_khz_type n, input cirbd_pkg::cirbd_range_type r);
      logic [19:0] p;
      p = 20'(n) * 20'(r);
      half_f = p[19:4];
   endfunction

   always_comb begin
      nominal = nom_f(carrier_freq_code, high_carrier_select);
      win_min = nominal - half_f(nominal, demod_range_code);
      win_max = nominal + half_f(nominal, demod_range_code);
   end

   // Register file: a write lands at the edge that takes the request
   always_comb begin
      next_ctrl = ctrl;
      next_div_low = div_low;
      next_div_high = div_high;
      next_bank = bank;
      if (wr) begin
         case (adr_i)
            `CIRBD_OFF_CTRL: next_ctrl = dat_i;
            `CIRBD_OFF_LOW: begin
               // Status side is read-only, so a write there is dropped
               if (bank_select_bit) begin
                  next_div_low = dat_i;
               end
            end
            `CIRBD_OFF_HIGH: begin
               if (bank_select_bit) begin
                  next_div_high = dat_i;
               end
            end
            `CIRBD_OFF_BANK: next_bank = dat_i;
            default: ;
         endcase
      end
   end

   // Read path: data is registered and stands with the acknowledge
   always_comb begin
      next_ack = cyc_i & stb_i & ~ack_o;
      next_dat = 8'h00;
      case (adr_i)
         `CIRBD_OFF_CTRL: next_dat = ctrl;
         `CIRBD_OFF_LOW:  next_dat = bank_select_bit ? div_low :
                             {2'b00, tx_fifo_byte_count_i};
         `CIRBD_OFF_HIGH: next_dat = bank_select_bit ? div_high : 8'h00;
         `CIRBD_OFF_BANK: next_dat = bank;
         default: next_dat = 8'h00;
      endcase
   end

   // Divisor zero stalls the baud clock rather than dividing by zero
   always_comb begin
      next_tick = 1'b0;
      next_baud_cnt = baud_cnt;
      if ({div_high, div_low} != 16'h0000) begin
         if (baud_cnt + 16'h0001 >= {div_high, div_low}) begin
            next_baud_cnt = 16'h0000;
            next_tick = 1'b1;
         end else begin
            next_baud_cnt = baud_cnt + 16'h0001;
         end
      end else begin
         next_baud_cnt = 16'h0000;
      end
   end

   // Verdict only moves on a strobe, so software sees a steady answer
   always_comb begin
      next_accept = carrier_accept_o;
      if (carrier_valid_i) begin
         next_accept = (demod_range_code != 3'h0) &&
                       (carrier_khz16_i >= win_min) &&
                       (carrier_khz16_i <= win_max);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl <= {`CIRBD_CFQ_RESET, `CIRBD_CTRL_LOW_RST};
         div_low <= `CIRBD_DIV_RESET;
         div_high <= `CIRBD_DIV_RESET;
         bank <= `CIRBD_BANK_RESET;
         dat_o <= 8'h00;
         ack_o <= 1'b0;
         baud_cnt <= 16'h0000;
         baud_tick_o <= 1'b0;
         carrier_accept_o <= 1'b0;
      end else if (ce_i) begin
         ctrl <= next_ctrl;
         div_low <= next_div_low;
         div_high <= next_div_high;
         bank <= next_bank;
         dat_o <= next_dat;
         ack_o <= next_ack;
         baud_cnt <= next_baud_cnt;
         baud_tick_o <= next_tick;
         carrier_accept_o <= next_accept;
      end
   end

   property p_ack_one;
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && ack_o) |=> !ack_o;
   endproperty
   a_ack_one: assert property (p_ack_one) else $error("ack held");

   property p_status_read;
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && cyc_i && stb_i && !we_i && !ack_o && adr_i == `CIRBD_OFF_LOW
       && !bank_select_bit)
      |=> dat_o == {2'b00, $past(tx_fifo_byte_count_i)};
   endproperty
   a_status_read: assert property (p_status_read) else $error("bad level");

   property p_ro_write;
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && wr && adr_i == `CIRBD_OFF_LOW && !bank_select_bit)
      |=> $stable(div_low);
   endproperty
   a_ro_write: assert property (p_ro_write) else $error("ro written");

   property p_low_write;
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && wr && adr_i == `CIRBD_OFF_LOW && bank_select_bit)
      |=> div_low == $past(dat_i);
   endproperty
   a_low_write: assert property (p_low_write) else $error("low lost");

   property p_high_write;
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && wr && adr_i == `CIRBD_OFF_HIGH && bank_select_bit)
      |=> div_high == $past(dat_i);
   endproperty
   a_high_write: assert property (p_high_write) else $error("high lost");

   property p_tick_bound;
      @(posedge clk_i) disable iff (rst_i)
      baud_cnt < {div_high, div_low} || {div_high, div_low} == 16'h0000
      || !$stable({div_high, div_low});
   endproperty
   a_tick_bound: assert property (p_tick_bound) else $error("count over");

   property p_win_32k;
      @(posedge clk_i) disable iff (rst_i)
      (!high_carrier_select && carrier_freq_code == 5'h05
       && demod_range_code == 3'h1) |-> win_min == 16'(30*16)
       && win_max == 16'(34*16);
   endproperty
   a_win_32k: assert property (p_win_32k) else $error("low window");

   property p_win_400k;
      @(posedge clk_i) disable iff (rst_i)
      (high_carrier_select && carrier_freq_code == 5'h03
       && demod_range_code == 3'h1) |-> win_min == 16'(375*16)
       && win_max == 16'(425*16);
   endproperty
   a_win_400k: assert property (p_win_400k) else $error("high window");

   property p_cfq_reset;
      @(posedge clk_i) $fell(rst_i) |-> carrier_freq_code == `CIRBD_CFQ_RESET;
   endproperty
   a_cfq_reset: assert property (p_cfq_reset) else $error("cfq reset");

   // A request the slave takes: idle, clocking and strobed
   sequence s_req;
      ce_i && cyc_i && stb_i && !ack_o;
   endsequence

   sequence s_read;
      s_req ##0 !we_i;
   endsequence

   property p_ack_taken;
      @(posedge clk_i) disable iff (rst_i)
      s_req |=> ack_o;
   endproperty
   a_ack_taken: assert property (p_ack_taken) else $error("no ack");

   property p_ctrl_read;
      @(posedge clk_i) disable iff (rst_i)
      s_read ##0 adr_i == `CIRBD_OFF_CTRL |=> dat_o == $past(ctrl);
   endproperty
   a_ctrl_read: assert property (p_ctrl_read) else $error("ctrl read");

   property p_ctrl_write;
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && wr && adr_i == `CIRBD_OFF_CTRL) |=> ctrl == $past(dat_i);
   endproperty
   a_ctrl_write: assert property (p_ctrl_write) else $error("ctrl lost");

   property p_high_ro;
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && wr && adr_i == `CIRBD_OFF_HIGH && !bank_select_bit)
      |=> $stable(div_high);
   endproperty
   a_high_ro: assert property (p_high_ro) else $error("high written");

   property p_high_status;
      @(posedge clk_i) disable iff (rst_i)
      s_read ##0 (adr_i == `CIRBD_OFF_HIGH && !bank_select_bit)
      |=> dat_o == 8'h00;
   endproperty
   a_high_status: assert property (p_high_status) else $error("6h read");

   // With a divisor above one a tick never repeats on the next clock
   property p_tick_gap;
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && baud_tick_o && {div_high, div_low} > 16'h0001
       && $stable({div_high, div_low})) |=> !baud_tick_o;
   endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("tick twice");

   property p_zero_div;
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && {div_high, div_low} == 16'h0000
       && $stable({div_high, div_low})) |=> !baud_tick_o;
   endproperty
   a_zero_div: assert property (p_zero_div) else $error("zero ticks");

   property p_accept_hold;
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && !carrier_valid_i) |=> $stable(carrier_accept_o);
   endproperty
   a_accept_hold: assert property (p_accept_hold) else $error("accept moved");

   // Enable low must freeze ctrl, the baud count, ack, tick and verdict
   property p_freeze;
      @(posedge clk_i) disable iff (rst_i)
      !ce_i |=> $stable(ctrl) && $stable(baud_cnt) && $stable(ack_o)
       && $stable(baud_tick_o) && $stable(carrier_accept_o);
   endproperty
   a_freeze: assert property (p_freeze) else $error("not frozen");
endmodule

// ---- sim/cirbd_ir_front.sv ----
// Infrared front end stand-in: strobes one measured carrier per request
// and reports the transmit FIFO level. Assumes one-cycle send requests.
module cirbd_ir_front (
   // Clock
   input  wire logic        clk_i,
   // Bench requests
   input  wire logic        send_i,
   input  wire logic [15:0] freq_i,
   input  wire logic [5:0]  level_i,
   // Toward the block
   output logic      [15:0] carrier_khz16_o,
   output logic             carrier_valid_o,
   output logic      [5:0]  tx_fifo_byte_count_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      carrier_khz16_o = 16'h0000;
      carrier_valid_o = 1'b0;
   end
   assign tx_fifo_byte_count_o = level_i;
   always @(posedge clk_i) begin
      carrier_valid_o <= send_i;
      // Between strobes the value means nothing, so keep it moving
      carrier_khz16_o <= send_i ? freq_i : ~carrier_khz16_o;
   end
endmodule

// ---- sim/cir_baud_demod_txstatus_bench.sv ----
// Self-checking bench for the baud, window and level block.
// Assumes 50 MHz clk_i and a one-cycle Wishbone answer.
module cir_baud_demod_txstatus_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i = 0, rst_i = 1, ce_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
   logic send = 0, ack_o, vld, acc_o, tick_o;
   logic [0:0] sel_i = 1'h1;
   logic [2:0] adr_i = 3'h0;
   logic [7:0] dat_i = 8'h00, dat_o, rd, m_ctrl = 8'h5c, m_bnk = 8'h04;
   logic [7:0] m_lo = 8'h00, m_hi = 8'h00;
   logic [5:0] lvl = 6'h00, cnt;
   logic [15:0] fq = 16'h0000, khz;
   int fails = 0, n_tests = 0, cyc_n = 0, k, n;
   int seed = 32'ha8cde4cb;
   cirbd_top u_cirbd_top (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i,
      .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .tx_fifo_byte_count_i(cnt),
      .carrier_khz16_i(khz), .carrier_valid_i(vld),
      .carrier_accept_o(acc_o), .baud_tick_o(tick_o));
   cirbd_ir_front u_cirbd_ir_front (.clk_i(clk_i), .send_i(send),
      .freq_i(fq), .level_i(lvl), .carrier_khz16_o(khz),
      .carrier_valid_o(vld), .tx_fifo_byte_count_o(cnt));
   initial begin
      forever #10 clk_i = ~clk_i;
   end
   task tally_and_finish;
      $display("fails=%0d n_tests=%0d", fails, n_tests);
      if (fails == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc_n++;
      if (cyc_n == 5000) begin
         fails++;
         tally_and_finish;
      end
   end
   task check(input logic [15:0] seen, input logic [15:0] want);
      n_tests++;
      if (seen !== want) begin
         fails++;
         $display("wrong value at %0t: got %h want %h", $time, seen, want);
      end
   endtask
   function logic [7:0] exp_rd(input logic [2:0] a);
      case (a)
         3'h4: exp_rd = m_ctrl;
         3'h5: exp_rd = m_bnk[0] ? m_lo : {2'h0, lvl};
         3'h6: exp_rd = m_bnk[0] ? m_hi : 8'h00;
         3'h7: exp_rd = m_bnk;
         default: exp_rd = 8'h00;
      endcase
   endfunction
   task wb(input logic w, input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_i);
      {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (ack_o !== 1'b1 && k < 50);
      rd = dat_o;
      {cyc_i, stb_i} <= 2'b00;
      if (k >= 50) fails++;
      if (!w) check(rd, exp_rd(a));
      else if (a == 3'h4) m_ctrl = d;
      else if (a == 3'h7) m_bnk = d;
      else if (a == 3'h5 && m_bnk[0]) m_lo = d;
      else if (a == 3'h6 && m_bnk[0]) m_hi = d;
   endtask
   task read_all;
      for (int a = 0; a < 8; a++) wb(0, a[2:0], 8'h00);
   endtask
   // Probes just outside and on both edges of a window
   task win(input int mn, input int mx);
      int f[4];
      f = '{mn - 1, mn, mx, mx + 1};
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_i);
         send <= 1'b1;
         fq <= f[i][15:0];
         @(posedge clk_i);
         send <= 1'b0;
         repeat (2) @(posedge clk_i);
         check(acc_o, 16'(i == 1 || i == 2));
      end
   endtask
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      read_all;
      lvl <= 6'($random(seed));
      wb(1, 3'h5, 8'($random(seed)));
      wb(1, 3'h6, 8'($random(seed)));
      wb(1, 3'h2, 8'h5a);
      read_all;
      wb(1, 3'h7, 8'h05);
      wb(1, 3'h5, 8'($random(seed)));
      wb(1, 3'h6, 8'($random(seed)));
      read_all;
      n = ($random(seed) & 7) + 2;
      wb(1, 3'h6, 8'h00);
      wb(1, 3'h5, 8'(n));
      for (k = 0; tick_o !== 1'b1 && k < 100; k++) @(posedge clk_i);
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (tick_o !== 1'b1 && k < 100);
      check(16'(k), 16'(n));
      ce_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      ce_i <= 1'b1;
      wb(1, 3'h4, 8'h2c);
      wb(1, 3'h7, 8'h04);
      win(30 * 16, 34 * 16);
      wb(1, 3'h4, 8'h1c);
      wb(1, 3'h7, 8'h06);
      win(375 * 16, 425 * 16);
      tally_and_finish;
   end
endmodule
